// file: src/cfg_i2c_pkg.sv
/*
 * Shared constants for the two-wire configuration read/write port: the fixed
 * part of the target address, command codes, packet byte positions and
 * the bit timing of the bus master.
 * Assumes a 40 MHz MCLK in every end that uses it.
 */
package cfg_i2c_pkg;
    localparam logic [3:0] ADDR_FIXED_HI = 4'h7;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_READ = 3'h4;
    localparam logic [1:0] PORT_RSVD = 2'h3;
    localparam logic [3:0] BYTE_ADDR = 4'h0;
    localparam logic [3:0] BYTE_CMD0 = 4'h1;
    localparam logic [3:0] BYTE_CMD1 = 4'h2;
    localparam logic [3:0] BYTE_CMD2 = 4'h3;
    localparam logic [3:0] BYTE_CMD3 = 4'h4;
    localparam logic [3:0] BYTE_DATA_LAST = 4'h8;
    localparam logic [3:0] BYTE_RD_ADDR = 4'h5;
    localparam logic [3:0] BYTE_RD_FIRST = 4'h6;
    localparam logic [3:0] BYTE_RD_LAST = 4'h9;
    localparam logic [3:0] BYTE_CNT_MAX = 4'hf;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam int CLK_KHZ = 40000;
    localparam int BUS_RATE_KBPS = 100;
    localparam int QUARTER_CYC = CLK_KHZ / (BUS_RATE_KBPS * 4);
    localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);
    localparam logic [1:0] PHASE_LAST = 2'h3;
endpackage

// file: src/i2c_link_if.sv
/*
 * Open-drain clock and data wires between the bus master and the target.
 * Assumes external pull-ups: a wire is low only while some party enables
 * its driver with a low output.
 */
`timescale 1ns/1ps
interface i2c_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic tgt_scl_o;
    logic tgt_scl_oe;
    logic tgt_sda_o;
    logic tgt_sda_oe;
    logic scl;
    logic sda;

    assign scl = (host_scl_oe ? host_scl_o : 1'b1)
               & (tgt_scl_oe ? tgt_scl_o : 1'b1);
    assign sda = (host_sda_oe ? host_sda_o : 1'b1)
               & (tgt_sda_oe ? tgt_sda_o : 1'b1);

    modport host (output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe,
                  input scl, input sda);
    modport target (output tgt_scl_o, output tgt_scl_oe,
                    output tgt_sda_o, output tgt_sda_oe,
                    input scl, input sda);
endinterface

// file: src/pin_sync.sv
/*
 * Two-stage synchroniser for pins that arrive from outside the MCLK domain.
 * Assumes idle-high inputs, so both stages reset to one.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d.meta = async_in;
        d.stable = q.meta;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.stable;
endmodule

// file: src/cfg_i2c_target.sv
/*
 * Two-wire bus target that turns register write packets into one-cycle
 * register write requests and serves reads from a 32-bit buffer.
 * Assumes the register file outside applies REG_BE itself and answers a
 * REG_RD pulse with REG_RDATA in the same cycle.
 */
`timescale 1ns/1ps
module cfg_i2c_target (
    input wire logic MCLK,
    input wire logic RST_N,
    i2c_link_if.target LINK,
    input wire logic [2:0] ADDR_STRAP,
    output logic REG_WR,
    output logic REG_RD,
    output logic [1:0] REG_PORT,
    output logic [11:0] REG_ADDR,
    output logic [3:0] REG_BE,
    output logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA
);
    typedef enum logic [2:0] {
        T_IDLE, T_RX, T_ACK, T_TX, T_TXACK, T_SKIP
    } tstate_e;

    typedef struct packed {
        tstate_e st;
        logic [3:0] bit_cnt;
        logic [3:0] byte_cnt;
        logic [7:0] sh;
        logic rw;
        logic ack_ok;
        logic commit;
        logic [7:0] cmd0;
        logic [7:0] cmd1;
        logic [7:0] cmd2;
        logic [7:0] cmd3;
        logic [31:0] data;
        logic [31:0] rbuf;
        logic [1:0] tx_idx;
        logic scl_d;
        logic sda_d;
        logic sda_oe;
        logic wr;
        logic rd;
        logic [1:0] port;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } tgt_s;

    tgt_s q;
    tgt_s n;
    logic [4:0] pins;
    logic scl;
    logic sda;
    logic [2:0] strap;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    function automatic logic [1:0] port_of(input logic [7:0] c1,
                                           input logic [7:0] c2);
        port_of = {c1[0], c2[7]};
    endfunction

    function automatic logic [11:0] addr_of(input logic [7:0] c2,
                                            input logic [7:0] c3);
        addr_of = {c2[1:0], c3, 2'h0};
    endfunction

    function automatic logic [7:0] buf_byte(input logic [31:0] b,
                                            input logic [1:0] idx);
        case (idx)
            2'h0: buf_byte = b[31:24];
            2'h1: buf_byte = b[23:16];
            2'h2: buf_byte = b[15:8];
            default: buf_byte = b[7:0];
        endcase
    endfunction

    // Straps ride the same synchroniser so a late strap settles cleanly.
    pin_sync #(.W(5)) u_sync (
        .mclk(MCLK),
        .rst_n(RST_N),
        .async_in({ADDR_STRAP, LINK.sda, LINK.scl}),
        .sync_out(pins)
    );

    assign scl = pins[0];
    assign sda = pins[1];
    assign strap = pins[4:2];
    assign rise = scl & ~q.scl_d;
    assign fall = ~scl & q.scl_d;
    assign start = scl & q.scl_d & q.sda_d & ~sda;
    assign stop = scl & q.scl_d & ~q.sda_d & sda;

    always_comb begin
        logic ack;
        ack = 1'b0;
        n = q;
        n.wr = 1'b0;
        n.rd = 1'b0;
        n.scl_d = scl;
        n.sda_d = sda;
        if (q.rd) begin
            n.rbuf = REG_RDATA;
        end
        if (start) begin
            // A repeated START keeps the command and buffer of the packet.
            n.st = T_RX;
            n.bit_cnt = 4'h0;
            n.byte_cnt = cfg_i2c_pkg::BYTE_ADDR;
            n.sda_oe = 1'b0;
            n.commit = 1'b0;
        end else if (stop) begin
            n.st = T_IDLE;
            n.sda_oe = 1'b0;
            n.commit = 1'b0;
        end else begin
            case (q.st)
                T_RX: begin
                    if (rise) begin
                        n.sh = {q.sh[6:0], sda};
                        n.bit_cnt = 4'(q.bit_cnt + 4'h1);
                    end else if (fall &&
                                 q.bit_cnt == cfg_i2c_pkg::BITS_PER_BYTE) begin
                        ack = 1'b1;
                        case (q.byte_cnt)
                            cfg_i2c_pkg::BYTE_ADDR: begin
                                ack = (q.sh[7:1] ==
                                       {cfg_i2c_pkg::ADDR_FIXED_HI, strap});
                                n.rw = q.sh[0];
                                n.tx_idx = 2'h0;
                            end
                            cfg_i2c_pkg::BYTE_CMD0: n.cmd0 = q.sh;
                            cfg_i2c_pkg::BYTE_CMD1: n.cmd1 = q.sh;
                            cfg_i2c_pkg::BYTE_CMD2: n.cmd2 = q.sh;
                            cfg_i2c_pkg::BYTE_CMD3: begin
                                n.cmd3 = q.sh;
                                if (q.cmd0[2:0] == cfg_i2c_pkg::OP_READ &&
                                    port_of(q.cmd1, q.cmd2) !=
                                    cfg_i2c_pkg::PORT_RSVD) begin
                                    n.rd = 1'b1;
                                    n.port = port_of(q.cmd1, q.cmd2);
                                    n.addr = addr_of(q.cmd2, q.sh);
                                end
                            end
                            default: begin
                                if (q.byte_cnt <=
                                    cfg_i2c_pkg::BYTE_DATA_LAST) begin
                                    n.data = {q.data[23:0], q.sh};
                                    n.commit = (q.byte_cnt ==
                                        cfg_i2c_pkg::BYTE_DATA_LAST);
                                end else begin
                                    ack = 1'b0;
                                end
                            end
                        endcase
                        n.sda_oe = ack;
                        n.st = ack ? T_ACK : T_SKIP;
                        n.bit_cnt = 4'h0;
                        if (q.byte_cnt != cfg_i2c_pkg::BYTE_CNT_MAX) begin
                            n.byte_cnt = 4'(q.byte_cnt + 4'h1);
                        end
                    end
                end
                T_ACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.commit = 1'b0;
                        if (q.commit && q.cmd0[2:0] == cfg_i2c_pkg::OP_WRITE &&
                            port_of(q.cmd1, q.cmd2) !=
                            cfg_i2c_pkg::PORT_RSVD) begin
                            n.wr = 1'b1;
                            n.port = port_of(q.cmd1, q.cmd2);
                            n.addr = addr_of(q.cmd2, q.cmd3);
                            n.be = q.cmd2[5:2];
                            n.wdata = q.data;
                        end
                        if (q.rw && q.byte_cnt == cfg_i2c_pkg::BYTE_CMD0) begin
                            n.sh = buf_byte(q.rbuf, q.tx_idx);
                            n.sda_oe = ~n.sh[7];
                            n.st = T_TX;
                        end else begin
                            n.st = T_RX;
                        end
                    end
                end
                T_TX: begin
                    if (fall) begin
                        if (q.bit_cnt == cfg_i2c_pkg::BIT_LAST) begin
                            n.sda_oe = 1'b0;
                            n.st = T_TXACK;
                            n.tx_idx = 2'(q.tx_idx + 2'h1);
                        end else begin
                            n.bit_cnt = 4'(q.bit_cnt + 4'h1);
                            n.sh = {q.sh[6:0], 1'b0};
                            n.sda_oe = ~q.sh[6];
                        end
                    end
                end
                T_TXACK: begin
                    if (rise) begin
                        n.ack_ok = ~sda;
                    end else if (fall) begin
                        if (q.ack_ok) begin
                            n.sh = buf_byte(q.rbuf, q.tx_idx);
                            n.sda_oe = ~n.sh[7];
                            n.bit_cnt = 4'h0;
                            n.st = T_TX;
                        end else begin
                            n.st = T_SKIP;
                        end
                    end
                end
                T_IDLE, T_SKIP: n.sda_oe = 1'b0;
                default: n.st = T_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.st <= T_IDLE;
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // The target never stretches the clock and only ever pulls data low.
    assign LINK.tgt_scl_o = 1'b0;
    assign LINK.tgt_scl_oe = 1'b0;
    assign LINK.tgt_sda_o = 1'b0;
    assign LINK.tgt_sda_oe = q.sda_oe;
    assign REG_WR = q.wr;
    assign REG_RD = q.rd;
    assign REG_PORT = q.port;
    assign REG_ADDR = q.addr;
    assign REG_BE = q.be;
    assign REG_WDATA = q.wdata;
endmodule

// file: src/cfg_i2c_host.sv
/*
 * Bus master that issues one register write or one register read packet
 * per request, generating a 100 kbit/s clock by dividing MCLK.
 * Assumes no other master on the bus and a target that never stretches.
 */
`timescale 1ns/1ps
module cfg_i2c_host (
    input wire logic MCLK,
    input wire logic RST_N,
    i2c_link_if.host LINK,
    input wire logic REQ,
    input wire logic REQ_READ,
    input wire logic [6:0] REQ_TGT,
    input wire logic [1:0] REQ_PORT,
    input wire logic [11:0] REQ_ADDR,
    input wire logic [3:0] REQ_BE,
    input wire logic [31:0] REQ_WDATA,
    output logic BUSY,
    output logic DONE,
    output logic NACK,
    output logic [31:0] RDATA
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_e;

    typedef struct packed {
        hstate_e st;
        logic [6:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bit_cnt;
        logic [3:0] idx;
        logic [7:0] sh;
        logic scl_oe;
        logic sda_oe;
        logic rd;
        logic [6:0] tgt;
        logic [1:0] port;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic busy;
        logic done;
        logic nack;
    } host_s;

    host_s q;
    host_s n;
    logic sda;
    logic tick;
    logic rx;
    logic [3:0] last_idx;

    function automatic logic [7:0] pkt_byte(input host_s s,
                                            input logic [3:0] i);
        case (i)
            4'h0: pkt_byte = {s.tgt, 1'b0};
            4'h1: pkt_byte = {5'h0, s.rd ? cfg_i2c_pkg::OP_READ
                                         : cfg_i2c_pkg::OP_WRITE};
            4'h2: pkt_byte = {7'h0, s.port[1]};
            4'h3: pkt_byte = {s.port[0], 1'b0, s.be, s.addr[11:10]};
            4'h4: pkt_byte = s.addr[9:2];
            4'h5: pkt_byte = s.rd ? {s.tgt, 1'b1} : s.wdata[31:24];
            4'h6: pkt_byte = s.wdata[23:16];
            4'h7: pkt_byte = s.wdata[15:8];
            default: pkt_byte = s.wdata[7:0];
        endcase
    endfunction

    pin_sync #(.W(1)) u_sync (
        .mclk(MCLK),
        .rst_n(RST_N),
        .async_in(LINK.sda),
        .sync_out(sda)
    );

    assign tick = (q.qcnt == cfg_i2c_pkg::QUARTER_LAST);
    assign rx = q.rd && q.idx >= cfg_i2c_pkg::BYTE_RD_FIRST;
    assign last_idx = q.rd ? cfg_i2c_pkg::BYTE_RD_LAST
                           : cfg_i2c_pkg::BYTE_DATA_LAST;

    always_comb begin
        n = q;
        n.done = 1'b0;
        n.qcnt = tick ? 7'h0 : 7'(q.qcnt + 7'h1);
        if (tick) begin
            n.ph = 2'(q.ph + 2'h1);
        end
        case (q.st)
            H_IDLE: begin
                n.qcnt = 7'h0;
                n.ph = 2'h0;
                if (REQ) begin
                    n.st = H_START;
                    n.rd = REQ_READ;
                    n.tgt = REQ_TGT;
                    n.port = REQ_PORT;
                    n.addr = REQ_ADDR;
                    n.be = REQ_BE;
                    n.wdata = REQ_WDATA;
                    n.idx = 4'h0;
                    n.busy = 1'b1;
                    n.nack = 1'b0;
                end
            end
            H_START: begin
                // Also serves as repeated START, entered with the clock low.
                if (tick) begin
                    case (q.ph)
                        2'h0: n.sda_oe = 1'b0;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b1;
                        default: begin
                            n.scl_oe = 1'b1;
                            n.sh = pkt_byte(q, q.idx);
                            n.bit_cnt = 4'h0;
                            n.st = H_BIT;
                        end
                    endcase
                end
            end
            H_BIT: begin
                if (tick) begin
                    case (q.ph)
                        2'h0: begin
                            if (q.bit_cnt != cfg_i2c_pkg::BITS_PER_BYTE) begin
                                n.sda_oe = rx ? 1'b0 : ~q.sh[7];
                            end else begin
                                n.sda_oe = rx && (q.idx != last_idx);
                            end
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: begin
                            if (q.bit_cnt != cfg_i2c_pkg::BITS_PER_BYTE) begin
                                n.sh = {q.sh[6:0], sda};
                            end else if (!rx) begin
                                n.nack = sda;
                            end
                        end
                        default: begin
                            n.scl_oe = 1'b1;
                            if (q.bit_cnt != cfg_i2c_pkg::BITS_PER_BYTE) begin
                                n.bit_cnt = 4'(q.bit_cnt + 4'h1);
                            end else begin
                                if (rx) begin
                                    n.rdata = {q.rdata[23:0], q.sh};
                                end
                                n.bit_cnt = 4'h0;
                                if (q.nack || q.idx == last_idx) begin
                                    n.st = H_STOP;
                                end else begin
                                    n.idx = 4'(q.idx + 4'h1);
                                    n.sh = pkt_byte(q, n.idx);
                                    if (q.rd && q.idx ==
                                        cfg_i2c_pkg::BYTE_CMD3) begin
                                        n.st = H_START;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    case (q.ph)
                        2'h0: n.sda_oe = 1'b1;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b0;
                        default: begin
                            n.st = H_IDLE;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    endcase
                end
            end
            default: n.st = H_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.st <= H_IDLE;
        end else begin
            q <= n;
        end
    end

    assign LINK.host_scl_o = 1'b0;
    assign LINK.host_scl_oe = q.scl_oe;
    assign LINK.host_sda_o = 1'b0;
    assign LINK.host_sda_oe = q.sda_oe;
    assign BUSY = q.busy;
    assign DONE = q.done;
    assign NACK = q.nack;
    assign RDATA = q.rdata;
endmodule

// file: sim/cfg_i2c_link_sva.sv
/*
 * Wire checks for the two-wire link between the bus master and the target.
 * Assumes the plain signals of one i2c_link_if and the MCLK domain.
 */
`timescale 1ns/1ps
module cfg_i2c_link_sva (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic tgt_scl_o,
    input wire logic tgt_scl_oe,
    input wire logic tgt_sda_o,
    input wire logic tgt_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [8:0] low_cnt_q;
    logic [8:0] low_cnt_d;

    // Counts the samples of the current clock low phase.
    always_comb begin
        low_cnt_d = scl ? 9'h000 : low_cnt_q + 9'h001;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            low_cnt_q <= 9'h000;
        end else begin
            low_cnt_q <= low_cnt_d;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_open_drain_low: assert property (
        !host_scl_o && !host_sda_o && !tgt_scl_o && !tgt_sda_o)
        else $error("open drain driver shows a high output");
    a_target_no_clock: assert property (!tgt_scl_oe)
        else $error("target drives the clock wire");
    a_ack_on_low: assert property ($rose(tgt_sda_oe) |-> !scl)
        else $error("target pulls data while clock high");
    a_release_on_low: assert property ($fell(tgt_sda_oe) |-> !scl)
        else $error("target releases data while clock high");
    a_ack_stands: assert property (
        $rose(tgt_sda_oe) |=> tgt_sda_oe [*8])
        else $error("target data bit does not stand");
    a_low_phase_len: assert property (
        $rose(scl) |-> low_cnt_q == 9'h0c8)
        else $error("clock low phase length wrong");
    a_sda_framing: assert property (
        scl && $past(scl) && !$stable(sda) |-> !$stable(host_sda_oe))
        else $error("data changed by target while clock high");
    a_idle_release: assert property ($rose(RST_N) |-> scl && sda)
        else $error("wires not idle after reset");
endmodule

// file: sim/tb.sv
/*
 * Self-checking bench: master and target joined by one link; the master's
 * request side is driven and the target's register side is observed.
 * Assumes a register file that answers a read strobe in the same cycle.
 */
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic [6:0] req_tgt = 7'h00;
    logic [1:0] req_port = 2'h0;
    logic [11:0] req_addr = 12'h000;
    logic [3:0] req_be = 4'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [2:0] strap = 3'h5;
    logic [31:0] reg_rdata = 32'h0;
    logic busy, done, nack, reg_wr, reg_rd;
    logic [1:0] reg_port;
    logic [11:0] reg_addr;
    logic [3:0] reg_be;
    logic [31:0] reg_wdata, rdata;
    logic [6:0] own_tgt;
    int err_total = 0, n_checks = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0;

    i2c_link_if link();
    always #12.5 mclk = ~mclk;
    assign own_tgt = {1'b0, 3'h7, strap};

    cfg_i2c_host i_cfg_i2c_host (.MCLK(mclk), .RST_N(rst_n),
        .LINK(link.host), .REQ(req), .REQ_READ(req_read), .REQ_TGT(req_tgt),
        .REQ_PORT(req_port), .REQ_ADDR(req_addr), .REQ_BE(req_be),
        .REQ_WDATA(req_wdata), .BUSY(busy), .DONE(done), .NACK(nack),
        .RDATA(rdata));
    cfg_i2c_target i_cfg_i2c_target (.MCLK(mclk), .RST_N(rst_n),
        .LINK(link.target), .ADDR_STRAP(strap), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_PORT(reg_port), .REG_ADDR(reg_addr),
        .REG_BE(reg_be), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
    cfg_i2c_link_sva i_cfg_i2c_link_sva (.MCLK(mclk), .RST_N(rst_n),
        .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
        .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
        .tgt_scl_o(link.tgt_scl_o), .tgt_scl_oe(link.tgt_scl_oe),
        .tgt_sda_o(link.tgt_sda_o), .tgt_sda_oe(link.tgt_sda_oe),
        .scl(link.scl), .sda(link.sda));

    // The four packets take about 108000 cycles; beyond this it hangs.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (reg_wr === 1'b1) wr_cnt <= wr_cnt + 1;
        if (reg_rd === 1'b1) rd_cnt <= rd_cnt + 1;
        if (cyc == 115000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input logic rd, input logic [6:0] tgt,
                        input logic [1:0] port, input logic [11:0] addr,
                        input logic [3:0] be, input logic [31:0] data);
        int n;
        req <= 1'b1;
        req_read <= rd;
        req_tgt <= tgt;
        req_port <= port;
        req_addr <= addr;
        req_be <= be;
        req_wdata <= data;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'b1 && n < 10);
        req <= 1'b0;
        // A packet that never ends is caught by the cycle ceiling.
        while (done !== 1'b1) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task automatic t_write();
        int w0;
        w0 = wr_cnt;
        // Low address bits are set on purpose; they must not reach the port.
        send(1'b0, own_tgt, 2'h2, 12'hb4f, 4'h5, 32'h1234_5678);
        chk(32'(wr_cnt - w0), 32'h1);
        chk({28'h0, reg_be}, 32'h5);
        chk(reg_wdata, 32'h1234_5678);
        chk({30'h0, reg_port}, 32'h2);
        chk({20'h0, reg_addr}, 32'hb4c);
        chk({31'h0, nack}, 32'h0);
    endtask

    task automatic t_bad_addr();
        int w0;
        w0 = wr_cnt;
        send(1'b0, own_tgt ^ 7'h01, 2'h0, 12'h010, 4'hf,
             32'h0bad_0bad);
        chk({31'h0, nack}, 32'h1);
        chk(32'(wr_cnt - w0), 32'h0);
    endtask

    task automatic t_port3();
        int w0;
        w0 = wr_cnt;
        send(1'b0, own_tgt, 2'h3, 12'h020, 4'hf, 32'hdead_beef);
        chk(32'(wr_cnt - w0), 32'h0);
        chk({30'h0, reg_port}, 32'h2);
        chk(reg_wdata, 32'h1234_5678);
        chk({31'h0, nack}, 32'h0);
    endtask

    task automatic t_read();
        int w0;
        int r0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        reg_rdata <= 32'h9abc_def0;
        send(1'b1, own_tgt, 2'h1, 12'h02c, 4'hf, 32'h0);
        chk(rdata, 32'h9abc_def0);
        chk(32'(rd_cnt - r0), 32'h1);
        chk(32'(wr_cnt - w0), 32'h0);
        chk({30'h0, reg_port}, 32'h1);
        chk({20'h0, reg_addr}, 32'h02c);
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        t_write();
        t_bad_addr();
        t_port3();
        t_read();
        complete_run();
    end
endmodule
